// >>> hw/boot_loader_defines.svh
// Offsets, field positions, reset values, byte codes, RAM bases and FIFO depth of the boot loader
`ifndef BOOT_LOADER_DEFINES_SVH
`define BOOT_LOADER_DEFINES_SVH

`define ADDR_DEST       4'h0
`define ADDR_CTRL       4'h1
`define ADDR_STATUS     4'h2
`define ADDR_LEN        4'h3
`define ADDR_DIVISOR    4'h4
`define ADDR_ARRAY_SEL  4'h5

`define DEST_RESET      8'h00
`define DEST_ERR_BIT    7
`define DEST_MAX_OK     7'h03
`define CTRL_START_BIT  0

`define BYTE_SYNC       8'h00
`define BYTE_PING       8'h55
`define BYTE_OK         8'hAA
`define BYTE_FAIL       8'hFF

`define RAM_BASE_0      24'hFF9000
`define RAM_BASE_1      24'hFFA000
`define RAM_BASE_2      24'hFFB000
`define RAM_BASE_3      24'hFF8000

`define FIFO_DEPTH      16
`define DIV_RESET       16'h0000

`endif

// >>> hw/boot_loader_pkg.sv
// Types shared by the boot loader files
package boot_loader_pkg;
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_MEASURE,
    ST_SEND_SYNC,
    ST_WAIT_PING,
    ST_LEN_HI,
    ST_LEN_LO,
    ST_DATA,
    ST_ERASE,
    ST_RUN,
    ST_ABORT
  } boot_state_t;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_DATA,
    RX_STOP
  } rx_state_t;
endpackage

// >>> hw/byte_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              push;
  wire              pop;

  assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data_i;
        wr_ptr_reg          <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // byte_fifo

// >>> hw/serial_boot_loader.sv
// Boot-mode serial loader with download destination control
`timescale 1ns/1ps
`include "boot_loader_defines.svh"
module serial_boot_loader (
  // Clock, reset and boot mode
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        boot_mode_i,
  // Register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  // Boot serial channel
  input  wire logic        rxd_i,
  output logic             txd_o,
  // RAM write port
  output logic             ram_we_o,
  output logic      [23:0] ram_addr_o,
  output logic      [7:0]  ram_wdata_o,
  // Flash erase handshake
  output logic             erase_req_o,
  input  wire logic        erase_done_i,
  input  wire logic        erase_fail_i,
  input  wire logic        flash_blank_i,
  // Execution control
  output logic             run_boot_o,
  output logic             run_ram_o,
  output logic             download_go_o,
  output logic      [23:0] download_base_o
);
  // Stretch of each frame's low period with 9 low bits of H'00 incl start
  localparam logic [3:0] SYNC_LOW_BITS = 4'h9;

  function automatic logic [23:0] dest_base(input logic [1:0] code);
    case (code)
      2'h0:    dest_base = `RAM_BASE_0;
      2'h1:    dest_base = `RAM_BASE_1;
      2'h2:    dest_base = `RAM_BASE_2;
      default: dest_base = `RAM_BASE_3;
    endcase
  endfunction

  boot_loader_pkg::boot_state_t st_reg;
  boot_loader_pkg::rx_state_t   rx_st_reg;

  logic [2:0]  rx_sync_reg;
  logic        boot_seen_reg;
  logic [15:0] div_reg;
  logic [15:0] low_cnt_reg;
  logic [15:0] rx_cnt_reg;
  logic [2:0]  rx_bit_reg;
  logic [7:0]  rx_shift_reg;
  logic        rx_valid_reg;
  logic [7:0]  rx_byte_reg;
  logic [15:0] tx_cnt_reg;
  logic [3:0]  tx_bit_reg;
  logic [9:0]  tx_shift_reg;
  logic        tx_busy_reg;
  logic [15:0] len_reg;
  logic [15:0] left_reg;
  logic [23:0] ram_ptr_reg;
  logic [7:0]  dest_reg;
  logic [7:0]  array_sel_reg;
  logic        go_reg;
  logic [7:0]  rdata_reg;
  logic        ram_we_reg;
  logic [7:0]  ram_wdata_reg;
  logic        erase_req_reg;

  // Three-stage input; a change counts when stages two and three agree
  wire rx_level   = rx_sync_reg[1];
  wire rx_agree   = (rx_sync_reg[1] == rx_sync_reg[2]);
  wire rx_low     = rx_agree && !rx_level;
  wire rx_fall    = rx_agree && !rx_level && (rx_st_reg == boot_loader_pkg::RX_IDLE);
  wire [15:0] half_div = {1'b0, div_reg[15:1]};

  // Transmit FIFO feeding the serial sender
  logic       tx_push;
  logic [7:0] tx_push_data;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [7:0]  fifo_out_data;
  wire        tx_take = fifo_out_valid && !tx_busy_reg;

  byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) u_tx_fifo (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (tx_push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (tx_push_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (!tx_busy_reg),
    .out_data_o  (fifo_out_data)
  );

  // Sequence decode; a received byte waits while the FIFO is full
  wire rx_ok       = rx_valid_reg && fifo_in_ready;
  wire in_data     = (st_reg == boot_loader_pkg::ST_DATA);
  wire in_len      = (st_reg == boot_loader_pkg::ST_LEN_HI) ||
                     (st_reg == boot_loader_pkg::ST_LEN_LO);
  wire ping_hit    = (st_reg == boot_loader_pkg::ST_WAIT_PING) && rx_ok &&
                     (rx_byte_reg == `BYTE_PING);
  wire sync_push   = (st_reg == boot_loader_pkg::ST_SEND_SYNC) && fifo_in_ready;
  wire erase_ok    = (st_reg == boot_loader_pkg::ST_ERASE) &&
                     (flash_blank_i || erase_done_i) && !erase_fail_i && fifo_in_ready;
  wire erase_bad   = (st_reg == boot_loader_pkg::ST_ERASE) && !flash_blank_i &&
                     erase_fail_i && fifo_in_ready;

  always_comb begin
    tx_push      = 1'b0;
    tx_push_data = `BYTE_SYNC;
    if (sync_push) begin
      tx_push = 1'b1;
    end else if (ping_hit) begin
      tx_push      = 1'b1;
      tx_push_data = `BYTE_OK;
    end else if ((in_len || in_data) && rx_ok) begin
      tx_push      = 1'b1;
      tx_push_data = rx_byte_reg;
    end else if (erase_ok) begin
      tx_push      = 1'b1;
      tx_push_data = `BYTE_OK;
    end else if (erase_bad) begin
      tx_push      = 1'b1;
      tx_push_data = `BYTE_FAIL;
    end
  end

  // Register file decode
  wire dest_code_bad = (dest_reg[6:0] > `DEST_MAX_OK);
  wire start_wr  = reg_wr_i && (reg_addr_i == `ADDR_CTRL) &&
                   reg_wdata_i[`CTRL_START_BIT];
  wire [7:0] rd_mux =
    (reg_addr_i == `ADDR_DEST)      ? dest_reg :
    (reg_addr_i == `ADDR_CTRL)      ? {7'h00, go_reg} :
    (reg_addr_i == `ADDR_STATUS)    ? {4'h0, st_reg} :
    (reg_addr_i == `ADDR_LEN)       ? len_reg[7:0] :
    (reg_addr_i == `ADDR_DIVISOR)   ? div_reg[7:0] :
    (reg_addr_i == `ADDR_ARRAY_SEL) ? array_sel_reg : 8'h00;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dest_reg      <= `DEST_RESET;
      array_sel_reg <= 8'h00;
      go_reg        <= 1'b0;
      rdata_reg     <= 8'h00;
    end else begin
      rdata_reg <= reg_rd_i ? rd_mux : 8'h00;
      go_reg    <= 1'b0;
      if (reg_wr_i && (reg_addr_i == `ADDR_DEST)) begin
        dest_reg <= reg_wdata_i;
      end
      if (reg_wr_i && (reg_addr_i == `ADDR_ARRAY_SEL)) begin
        array_sel_reg <= reg_wdata_i;
      end
      if (start_wr && dest_code_bad) begin
        dest_reg[`DEST_ERR_BIT] <= 1'b1;
      end else if (start_wr && !dest_reg[`DEST_ERR_BIT]) begin
        go_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      download_base_o <= `RAM_BASE_0;
    end else if (start_wr && !dest_code_bad) begin
      download_base_o <= dest_base(dest_reg[1:0]);
    end
  end

  // Receiver: 8 data bits, one stop bit, no parity
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_sync_reg  <= 3'h7;
      rx_st_reg    <= boot_loader_pkg::RX_IDLE;
      rx_cnt_reg   <= 16'h0000;
      rx_bit_reg   <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_valid_reg <= 1'b0;
      rx_byte_reg  <= 8'h00;
    end else begin
      rx_sync_reg <= {rx_sync_reg[1:0], rxd_i};
      if (rx_ok) begin
        rx_valid_reg <= 1'b0;
      end
      case (rx_st_reg)
        boot_loader_pkg::RX_IDLE: begin
          if (rx_fall && (div_reg != 16'h0000)) begin
            rx_st_reg  <= boot_loader_pkg::RX_DATA;
            // Reload is one short: the zero count is a cycle too
            rx_cnt_reg <= div_reg + half_div - 16'h0001;
            rx_bit_reg <= 3'h0;
          end
        end
        boot_loader_pkg::RX_DATA: begin
          if (rx_cnt_reg != 16'h0000) begin
            rx_cnt_reg <= rx_cnt_reg - 16'h0001;
          end else begin
            rx_shift_reg <= {rx_level, rx_shift_reg[7:1]};
            rx_cnt_reg   <= div_reg - 16'h0001;
            rx_bit_reg   <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == 3'h7) begin
              rx_st_reg <= boot_loader_pkg::RX_STOP;
            end
          end
        end
        boot_loader_pkg::RX_STOP: begin
          if (rx_cnt_reg != 16'h0000) begin
            rx_cnt_reg <= rx_cnt_reg - 16'h0001;
          end else begin
            rx_st_reg    <= boot_loader_pkg::RX_IDLE;
            rx_valid_reg <= rx_level;
            rx_byte_reg  <= rx_shift_reg;
          end
        end
        default: rx_st_reg <= boot_loader_pkg::RX_IDLE;
      endcase
    end
  end

  // Transmitter drains the FIFO one character at a time
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_busy_reg  <= 1'b0;
      tx_cnt_reg   <= 16'h0000;
      tx_bit_reg   <= 4'h0;
      tx_shift_reg <= 10'h3FF;
      txd_o        <= 1'b1;
    end else if (tx_take) begin
      tx_busy_reg  <= 1'b1;
      tx_shift_reg <= {1'b1, fifo_out_data, 1'b0};
      tx_bit_reg   <= 4'h0;
      tx_cnt_reg   <= 16'h0000;
    end else if (tx_busy_reg) begin
      if (tx_cnt_reg == 16'h0000) begin
        txd_o        <= tx_shift_reg[0];
        tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
        tx_cnt_reg   <= div_reg - 16'h0001;
        tx_bit_reg   <= tx_bit_reg + 4'h1;
        tx_busy_reg  <= (tx_bit_reg != 4'hA);
      end else begin
        tx_cnt_reg <= tx_cnt_reg - 16'h0001;
      end
    end
  end

  // Boot sequence; the low span of H'00 is start plus eight zero bits
  wire low_ends = (st_reg == boot_loader_pkg::ST_MEASURE) && !rx_low &&
                  rx_agree && (low_cnt_reg != 16'h0000);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_reg        <= boot_loader_pkg::ST_IDLE;
      boot_seen_reg <= 1'b0;
      div_reg       <= `DIV_RESET;
      low_cnt_reg   <= 16'h0000;
      len_reg       <= 16'h0000;
      left_reg      <= 16'h0000;
      ram_ptr_reg   <= `RAM_BASE_3;
      ram_we_reg    <= 1'b0;
      ram_wdata_reg <= 8'h00;
      erase_req_reg <= 1'b0;
    end else begin
      ram_we_reg <= 1'b0;
      case (st_reg)
        boot_loader_pkg::ST_IDLE: begin
          if (!boot_seen_reg) begin
            boot_seen_reg <= 1'b1;
            if (boot_mode_i) begin
              st_reg <= boot_loader_pkg::ST_MEASURE;
            end
          end
        end
        boot_loader_pkg::ST_MEASURE: begin
          if (rx_low) begin
            low_cnt_reg <= low_cnt_reg + 16'h0001;
          end
          if (low_ends) begin
            // Rounded: the agree filter trims one cycle off the span
            div_reg <= (low_cnt_reg + 16'h0004) /
                       {12'h000, SYNC_LOW_BITS};
            st_reg  <= boot_loader_pkg::ST_SEND_SYNC;
          end
        end
        boot_loader_pkg::ST_SEND_SYNC: begin
          if (sync_push) begin
            st_reg <= boot_loader_pkg::ST_WAIT_PING;
          end
        end
        boot_loader_pkg::ST_WAIT_PING: begin
          if (ping_hit) begin
            st_reg <= boot_loader_pkg::ST_LEN_HI;
          end
        end
        boot_loader_pkg::ST_LEN_HI: begin
          if (rx_ok) begin
            len_reg[15:8] <= rx_byte_reg;
            st_reg        <= boot_loader_pkg::ST_LEN_LO;
          end
        end
        boot_loader_pkg::ST_LEN_LO: begin
          if (rx_ok) begin
            len_reg[7:0] <= rx_byte_reg;
            left_reg     <= {len_reg[15:8], rx_byte_reg};
            ram_ptr_reg  <= `RAM_BASE_3;
            st_reg       <= ({len_reg[15:8], rx_byte_reg} == 16'h0000) ?
                            boot_loader_pkg::ST_ERASE :
                            boot_loader_pkg::ST_DATA;
          end
        end
        boot_loader_pkg::ST_DATA: begin
          if (rx_ok) begin
            ram_we_reg    <= 1'b1;
            ram_wdata_reg <= rx_byte_reg;
            left_reg      <= left_reg - 16'h0001;
            if (left_reg == 16'h0001) begin
              st_reg <= boot_loader_pkg::ST_ERASE;
            end
          end
          if (ram_we_reg) begin
            ram_ptr_reg <= ram_ptr_reg + 24'h000001;
          end
        end
        boot_loader_pkg::ST_ERASE: begin
          if (ram_we_reg) begin
            ram_ptr_reg <= ram_ptr_reg + 24'h000001;
          end
          erase_req_reg <= !flash_blank_i && !erase_ok && !erase_bad;
          if (erase_ok) begin
            st_reg <= boot_loader_pkg::ST_RUN;
          end else if (erase_bad) begin
            st_reg <= boot_loader_pkg::ST_ABORT;
          end
        end
        boot_loader_pkg::ST_RUN:   st_reg <= boot_loader_pkg::ST_RUN;
        boot_loader_pkg::ST_ABORT: st_reg <= boot_loader_pkg::ST_ABORT;
        default: st_reg <= boot_loader_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      run_boot_o <= 1'b0;
      run_ram_o  <= 1'b0;
    end else begin
      run_boot_o <= (st_reg != boot_loader_pkg::ST_IDLE) &&
                    (st_reg != boot_loader_pkg::ST_RUN);
      run_ram_o  <= (st_reg == boot_loader_pkg::ST_RUN);
    end
  end

  assign reg_rdata_o   = rdata_reg;
  assign ram_we_o      = ram_we_reg;
  assign ram_addr_o    = ram_ptr_reg;
  assign ram_wdata_o   = ram_wdata_reg;
  assign erase_req_o   = erase_req_reg;
  assign download_go_o = go_reg;

  property p_range_err;
    @(posedge clk_i) disable iff (sys_rst_i)
      start_wr && dest_code_bad |=> dest_reg[`DEST_ERR_BIT] && !go_reg;
  endproperty
  a_range_err: assert property (p_range_err)
    else $error("range error not flagged");

  property p_fail_abort;
    @(posedge clk_i) disable iff (sys_rst_i)
      erase_bad |=> st_reg == boot_loader_pkg::ST_ABORT ##1 !run_ram_o [*3];
  endproperty
  a_fail_abort: assert property (p_fail_abort)
    else $error("erase failure did not abort");

  property p_run_after_ok;
    @(posedge clk_i) disable iff (sys_rst_i)
      erase_ok |-> ##2 run_ram_o;
  endproperty
  a_run_after_ok: assert property (p_run_after_ok)
    else $error("no branch to loaded program");

  property p_echo;
    @(posedge clk_i) disable iff (sys_rst_i)
      (in_len || in_data) && rx_ok |-> tx_push && tx_push_data == rx_byte_reg;
  endproperty
  a_echo: assert property (p_echo)
    else $error("received byte not echoed");

  property p_ping_reply;
    @(posedge clk_i) disable iff (sys_rst_i)
      ping_hit |-> tx_push && tx_push_data == `BYTE_OK;
  endproperty
  a_ping_reply: assert property (p_ping_reply)
    else $error("ping not answered");

  property p_start_go;
    @(posedge clk_i) disable iff (sys_rst_i)
      start_wr && !dest_code_bad && !dest_reg[`DEST_ERR_BIT] |=>
        go_reg && download_base_o == dest_base(dest_reg[1:0]);
  endproperty
  a_start_go: assert property (p_start_go)
    else $error("download start not taken");

  property p_erase_req;
    @(posedge clk_i) disable iff (sys_rst_i)
      st_reg == boot_loader_pkg::ST_ERASE && !flash_blank_i &&
        !erase_done_i && !erase_fail_i |=> erase_req_o;
  endproperty
  a_erase_req: assert property (p_erase_req)
    else $error("erase not requested");
endmodule // serial_boot_loader

// >>> verif/serial_host_model.sv
// Host computer model on the boot serial channel
`timescale 1ns/1ps
module serial_host_model #(
  parameter int BIT = 20
) (
  // Clock
  input  wire logic clk_i,
  // Serial lines
  output logic      rxd_o,
  input  wire logic txd_i
);
  // Line rests at mark level between characters
  initial rxd_o = 1'b1;

  // Start bit, eight data bits LSB first, one stop bit
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      rxd_o <= f[i];
      repeat (BIT - 1) @(posedge clk_i);
    end
  endtask

  // Samples mid-bit; a missing character comes back unknown
  task automatic recv_byte(output logic [7:0] b);
    int n;
    n = 0;
    b = 8'hXX;
    while (txd_i !== 1'b0 && n < 6000) begin
      @(posedge clk_i);
      n++;
    end
    if (n < 6000) begin
      repeat (BIT / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clk_i);
        b[i] = txd_i;
      end
      repeat (BIT) @(posedge clk_i);
      if (txd_i !== 1'b1) b = 8'hXX;
    end
  endtask
endmodule // serial_host_model

// >>> verif/tb.sv
// Self-checking bench for the boot loader
`timescale 1ns/1ps
`include "boot_loader_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %0t mismatch got %h exp %h", $time, g, e); end end
module tb;
  localparam int BIT = 20;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        boot_mode_i = 1'b0;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [7:0]  reg_rdata_o;
  logic        rxd;
  logic        txd_o;
  logic        ram_we_o;
  logic [23:0] ram_addr_o;
  logic [7:0]  ram_wdata_o;
  logic        erase_req_o;
  logic        erase_done_i = 1'b0;
  logic        erase_fail_i = 1'b0;
  logic        flash_blank_i = 1'b0;
  logic        run_boot_o;
  logic        run_ram_o;
  logic        download_go_o;
  logic [23:0] download_base_o;
  int          bad_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          ram_cnt = 0;
  logic [31:0] seed = 32'h57;
  logic [7:0]  exp_data [16];
  logic [7:0]  r;

  always #2.5 clk_i = ~clk_i;

  serial_boot_loader dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .boot_mode_i(boot_mode_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .rxd_i(rxd), .txd_o(txd_o),
    .ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o),
    .ram_wdata_o(ram_wdata_o), .erase_req_o(erase_req_o),
    .erase_done_i(erase_done_i), .erase_fail_i(erase_fail_i),
    .flash_blank_i(flash_blank_i), .run_boot_o(run_boot_o),
    .run_ram_o(run_ram_o), .download_go_o(download_go_o),
    .download_base_o(download_base_o));

  serial_host_model #(.BIT(BIT)) host (.clk_i(clk_i), .rxd_o(rxd),
    .txd_i(txd_o));

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic logic [23:0] exp_base(input logic [1:0] c);
    case (c)
      2'h0: return 24'hFF9000;
      2'h1: return 24'hFFA000;
      2'h2: return 24'hFFB000;
      default: return 24'hFF8000;
    endcase
  endfunction

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  task automatic reset_dut(input logic mode);
    @(posedge clk_i);
    boot_mode_i <= mode;
    sys_rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1 `CHK(run_boot_o, mode)
  endtask

  // Send and listen at once: the answer starts inside our stop bit
  task automatic xchg(input logic [7:0] tx, input logic [7:0] ex);
    logic [7:0] g;
    fork
      host.send_byte(tx);
      host.recv_byte(g);
    join
    `CHK(g, ex)
  endtask

  // Every store lands at the next RAM location with the echoed byte
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 30000) begin
      bad_count++;
      close_out();
    end
    if (ram_we_o === 1'b1) begin
      `CHK(ram_addr_o, 24'hFF8000 + 24'(ram_cnt))
      `CHK(ram_wdata_o, exp_data[ram_cnt[3:0]])
      ram_cnt++;
    end
  end

  task automatic boot_run(input logic [15:0] n, input logic fail,
                          input logic blank);
    logic [7:0] g;
    reset_dut(1'b1);
    @(posedge clk_i);
    erase_done_i  <= 1'b0;
    erase_fail_i  <= 1'b0;
    flash_blank_i <= blank;
    ram_cnt = 0;
    fork
      begin
        host.send_byte(`BYTE_SYNC);
        host.send_byte(`BYTE_SYNC);
      end
      host.recv_byte(g);
    join
    `CHK(g, `BYTE_SYNC)
    rd(`ADDR_DIVISOR, g);
    `CHK(g, 8'(BIT))
    xchg(`BYTE_PING, `BYTE_OK);
    xchg(n[15:8], n[15:8]);
    xchg(n[7:0], n[7:0]);
    for (int i = 0; i < n; i++) begin
      exp_data[i] = rnd();
      xchg(exp_data[i], exp_data[i]);
    end
    fork
      host.recv_byte(g);
      begin
        for (int k = 0; k < 300 && erase_req_o !== 1'b1; k++)
          @(posedge clk_i);
        `CHK(erase_req_o, ~blank)
        erase_done_i <= ~blank;
        erase_fail_i <= fail;
      end
    join
    `CHK(g, fail ? `BYTE_FAIL : `BYTE_OK)
    `CHK(ram_cnt, int'(n))
    rd(`ADDR_STATUS, g);
    `CHK(g, fail ? 8'h09 : 8'h08)
    `CHK(run_ram_o, ~fail)
    $display("Boot run with %0d bytes done", n);
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    logic [7:0] bad [3];
    reset_dut(1'b0);
    rd(`ADDR_DEST, r);
    `CHK(r, `DEST_RESET)
    rd(4'hF, r);
    `CHK(r, 8'h00)
    wr(`ADDR_ARRAY_SEL, 8'h5A);
    rd(`ADDR_ARRAY_SEL, r);
    `CHK(r, 8'h5A)
    for (int c = 0; c < 4; c++) begin
      wr(`ADDR_DEST, 8'(c));
      wr(`ADDR_CTRL, 8'h01);
      #1 `CHK(download_go_o, 1'b1)
      `CHK(download_base_o, exp_base(2'(c)))
      @(posedge clk_i);
      #1 `CHK(download_go_o, 1'b0)
    end
    $display("Destination codes done");
    // Edge codes plus one random out-of-range code
    bad = '{8'h04, 8'h7F, 8'h04 + (rnd() % 8'h7C)};
    foreach (bad[i]) begin
      wr(`ADDR_DEST, bad[i]);
      wr(`ADDR_CTRL, 8'h01);
      #1 `CHK(download_go_o, 1'b0)
      rd(`ADDR_DEST, r);
      `CHK(r, {1'b1, bad[i][6:0]})
      wr(`ADDR_DEST, 8'h00);
      rd(`ADDR_DEST, r);
      `CHK(r, 8'h00)
    end
    $display("Range errors done");
    boot_run(16'h0008, 1'b0, 1'b0);
    boot_run(16'h0000, 1'b1, 1'b0);
    // Blank flash skips the erase request
    boot_run(16'h0003, 1'b0, 1'b1);
    close_out();
  end
endmodule // tb
